// >>> bench/bavd_bridge_monitor.sv
`timescale 1ns/1ps
module bavd_bridge_monitor
	import bavd_pkg::*;
(
	// clock, reset and register port
	input wire logic        sys_clk,
	input wire logic        reset_n,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	// decode
	input wire logic        memory_space_enable,
	input wire logic        pri_valid,
	input wire logic        pri_is_io,
	input wire logic [31:0] pri_addr,
	input wire logic        pri_forward,
	// aborts
	input wire logic        pci_master_abort,
	input wire logic        pci_abort_is_read,
	input wire logic        pci_abort_posted,
	input wire logic        pcie_ur_received,
	input wire logic        pcie_send_ur,
	input wire logic        pci_signal_ta,
	input wire logic        posted_abort_err,
	input wire logic        abort_drop_write,
	input wire logic        abort_rdata_valid,
	input wire logic [31:0] abort_rdata
);
	// shadow of the control bits, follows every software write
	logic [15:0] ctl_r;
	logic        vmem;
	assign vmem = pri_addr >= VGA_MEM_LO && pri_addr <= VGA_MEM_HI;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) ctl_r <= 16'h0000;
		else if (reg_wr && reg_addr == ADDR_BRIDGE_CONTROL) ctl_r <= reg_wdata;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	AST_NO_UR_QUIET: assert property (
		pci_master_abort && !ctl_r[5] |=> !pcie_send_ur) else $error("ur sent");
	AST_RD_ONES: assert property (
		pci_master_abort && pci_abort_is_read && !ctl_r[5] |=>
		abort_rdata_valid && abort_rdata == ABORT_READ_DATA) else $error("rd");
	AST_WR_DROP: assert property (
		pci_master_abort && !pci_abort_is_read && !ctl_r[5] |=>
		abort_drop_write) else $error("write not dropped");
	AST_UR_SENT: assert property (
		pci_master_abort && ctl_r[5] |=> pcie_send_ur) else $error("no ur");
	AST_TA_SENT: assert property (
		pcie_ur_received && ctl_r[5] |=>
		pci_signal_ta) else $error("no target abort");
	AST_PW_ERR: assert property (
		pci_master_abort && pci_abort_posted |=>
		posted_abort_err == $past(ctl_r[5])) else $error("posted err");
	AST_VGA_MEM: assert property (
		pri_valid && !pri_is_io && vmem && ctl_r[3] && memory_space_enable
		|=> pri_forward) else $error("vga memory not claimed");
	AST_MEM_GATE: assert property (
		pri_valid && !pri_is_io && !memory_space_enable |=> !pri_forward)
		else $error("memory forwarded while disabled");
endmodule // bavd_bridge_monitor
bind bavd_bridge bavd_bridge_monitor bavd_bridge_monitor_i (
	.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.memory_space_enable(memory_space_enable), .pri_valid(pri_valid),
	.pri_is_io(pri_is_io), .pri_addr(pri_addr), .pri_forward(pri_forward),
	.pci_master_abort(pci_master_abort), .pci_abort_is_read(pci_abort_is_read),
	.pci_abort_posted(pci_abort_posted), .pcie_ur_received(pcie_ur_received),
	.pcie_send_ur(pcie_send_ur), .pci_signal_ta(pci_signal_ta),
	.posted_abort_err(posted_abort_err), .abort_drop_write(abort_drop_write),
	.abort_rdata_valid(abort_rdata_valid), .abort_rdata(abort_rdata));

// >>> bench/bavd_far_end.sv
`timescale 1ns/1ps
module bavd_far_end (
	// clock
	input  wire logic sys_clk,
	// abort events toward the bridge
	output logic      pci_master_abort = 1'b0,
	output logic      pci_abort_is_read = 1'b0,
	output logic      pci_abort_posted = 1'b0,
	output logic      pcie_ur_received = 1'b0
);
	// one-cycle event; qualifiers flip afterwards so stale values never help
	task ev(input logic ma, input logic rd, input logic po, input logic ur);
		@(posedge sys_clk);
		pci_master_abort <= ma;
		pci_abort_is_read <= rd;
		pci_abort_posted <= po;
		pcie_ur_received <= ur;
		@(posedge sys_clk);
		pci_master_abort <= 1'b0;
		pcie_ur_received <= 1'b0;
		pci_abort_is_read <= ~rd;
		pci_abort_posted <= ~po;
	endtask
endmodule // bavd_far_end

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
	import bavd_pkg::*;
;
	logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000, reg_rdata;
	logic io_space_enable = 1'b1, memory_space_enable = 1'b1;
	logic pri_valid = 1'b0, pri_is_io = 1'b0, pri_in_window = 1'b0;
	logic sec_valid = 1'b0, sec_is_io = 1'b0, sec_in_window = 1'b0;
	logic [31:0] pri_addr = 32'h0, sec_addr = 32'h0, abort_rdata;
	logic pri_forward, sec_forward, ma, ard, apo, urr, ur, ta, perr, drop, arv;
	logic irq;
	int num_errors = 0, total_checks = 0, cyc = 0;
	always #10 sys_clk = ~sys_clk;
	bavd_bridge bavd_bridge_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.io_space_enable(io_space_enable),
		.memory_space_enable(memory_space_enable), .pri_valid(pri_valid),
		.pri_is_io(pri_is_io), .pri_addr(pri_addr),
		.pri_in_window(pri_in_window), .pri_forward(pri_forward),
		.sec_valid(sec_valid), .sec_is_io(sec_is_io), .sec_addr(sec_addr),
		.sec_in_window(sec_in_window), .sec_forward(sec_forward),
		.pci_master_abort(ma), .pci_abort_is_read(ard),
		.pci_abort_posted(apo), .pcie_ur_received(urr), .pcie_send_ur(ur),
		.pci_signal_ta(ta), .posted_abort_err(perr), .abort_drop_write(drop),
		.abort_rdata_valid(arv), .abort_rdata(abort_rdata), .irq(irq));
	bavd_far_end bavd_far_end_i (.sys_clk(sys_clk), .pci_master_abort(ma),
		.pci_abort_is_read(ard), .pci_abort_posted(apo),
		.pcie_ur_received(urr));
	task test_done;
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task chk(input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0; reg_wdata <= ~d;
	endtask
	task rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge sys_clk);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk) chk(reg_rdata, e);
	endtask
	// control value, io, address, in window, expected down, expected up
	task dec(input logic [15:0] c, input logic io, input logic [31:0] a,
		input logic w, input logic ep, input logic es);
		wr(ADDR_BRIDGE_CONTROL, c);
		pri_valid <= 1'b1; pri_is_io <= io; pri_addr <= a; pri_in_window <= w;
		sec_valid <= 1'b1; sec_is_io <= io; sec_addr <= a;
		sec_in_window <= w;
		@(posedge sys_clk);
		pri_valid <= 1'b0; sec_valid <= 1'b0; pri_addr <= ~a; sec_addr <= ~a;
		@(negedge sys_clk) chk({pri_forward, sec_forward}, {ep, es});
	endtask
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			num_errors++;
			test_done;
		end
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(ADDR_BRIDGE_CONTROL, 16'h0000);
		wr(ADDR_BRIDGE_CONTROL, 16'hFFFF);
		rd(ADDR_BRIDGE_CONTROL, 16'h003C);
		wr(ADDR_IRQ_STATUS, 16'hFFFF);
		rd(ADDR_IRQ_STATUS, 16'h0000);
		rd(4'h7, 16'h0000);
		$display("test registers done");
		dec(16'h0008, 0, 32'h000A0000, 0, 1, 0);
		dec(16'h000C, 0, 32'h000BFFFF, 0, 1, 0);
		dec(16'h000C, 1, 32'h000003C0, 0, 1, 0);
		dec(16'h0008, 0, 32'h000C0000, 0, 0, 1);
		dec(16'h0008, 1, 32'h000003B0, 0, 1, 0);
		dec(16'h0008, 1, 32'h000003BC, 0, 0, 1);
		dec(16'h0008, 1, 32'h000003DF, 0, 1, 0);
		dec(16'h0008, 1, 32'h000103C0, 0, 0, 1);
		dec(16'h0008, 1, 32'h00007BC0, 0, 1, 0);
		dec(16'h0018, 1, 32'h00007BC0, 0, 0, 1);
		dec(16'h0010, 1, 32'h000003C0, 0, 0, 1);
		dec(16'h0000, 0, 32'h000A0000, 1, 1, 0);
		dec(16'h0000, 0, 32'h000A0000, 0, 0, 1);
		dec(16'h0004, 1, 32'h00000500, 1, 0, 0);
		dec(16'h0004, 1, 32'h00000400, 1, 1, 0);
		@(posedge sys_clk) memory_space_enable <= 1'b0;
		dec(16'h0008, 0, 32'h000A0000, 0, 0, 0);
		@(posedge sys_clk) io_space_enable <= 1'b0;
		dec(16'h0008, 1, 32'h000003B0, 0, 0, 0);
		$display("test decode done");
		wr(ADDR_BRIDGE_CONTROL, 16'h0000);
		wr(ADDR_IRQ_ENABLE, 16'h0007);
		bavd_far_end_i.ev(1, 1, 0, 0);
		@(negedge sys_clk)
			chk({arv, ur, abort_rdata}, {2'b10, 32'hFFFFFFFF});
		bavd_far_end_i.ev(1, 0, 1, 0);
		@(negedge sys_clk) chk({drop, perr, ur}, 3'b100);
		bavd_far_end_i.ev(0, 0, 0, 1);
		@(negedge sys_clk) chk({ta, irq}, 2'b00);
		rd(ADDR_IRQ_STATUS, 16'h0000);
		wr(ADDR_BRIDGE_CONTROL, 16'h0020);
		bavd_far_end_i.ev(1, 0, 1, 0);
		@(negedge sys_clk) chk({drop, perr, ur}, 3'b011);
		bavd_far_end_i.ev(0, 0, 0, 1);
		@(negedge sys_clk) chk({ta, irq}, 2'b11);
		rd(ADDR_IRQ_STATUS, 16'h0007);
		wr(ADDR_IRQ_CLEAR, 16'h0007);
		@(negedge sys_clk) chk(irq, 1'b0);
		wr(ADDR_IRQ_ENABLE, 16'h0000);
		bavd_far_end_i.ev(1, 1, 0, 0);
		@(negedge sys_clk) chk({ur, irq, arv}, 3'b100);
		rd(ADDR_IRQ_STATUS, 16'h0001);
		bavd_far_end_i.ev(1, 0, 0, 1);
		@(negedge sys_clk) chk({ur, ta}, 2'b11);
		rd(ADDR_IRQ_STATUS, 16'h0003);
		$display("test aborts done");
		@(posedge sys_clk) reset_n <= 1'b0;
		repeat (2) @(posedge sys_clk);
		reset_n <= 1'b1;
		rd(ADDR_BRIDGE_CONTROL, 16'h0000);
		$display("test reset done");
		test_done;
	end
endmodule // tb_top

// >>> rtl/bavd_bridge.sv
`timescale 1ns/1ps
// Overview of operation
// - abort mode clear: no abort report, reads give all ones, writes drop
// - abort mode set: pci master abort answered with unsupported request
// - abort mode set: pcie unsupported request gives target abort on pci
// - abort mode set: posted write master abort signals error, else quiet
// - full decode clear ignores io bits 15:10, set decodes them as zero
// - full decode only matters while vga enable is set
// - vga enable claims primary memory 000A0000h to 000BFFFFh downstream
// - vga enable forwards io, upper bits zero, 3B0-3BB or 3C0-3DF
// - vga enable blocks vga ranges from secondary going upstream
// - vga forwarding ignores isa enable and base limit windows
// - vga io gated by io enable, vga memory by memory enable, on the primary side only
// - vga enable clear: vga addresses go downstream only inside windows, upstream only outside them
// - isa enable blocks last 768 bytes of each 1 KB in first 64 KB
module bavd_bridge
	import bavd_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// command register enables
	input  wire logic        io_space_enable,
	input  wire logic        memory_space_enable,
	// primary side decode request
	input  wire logic        pri_valid,
	input  wire logic        pri_is_io,
	input  wire logic [31:0] pri_addr,
	input  wire logic        pri_in_window,
	output logic             pri_forward,
	// secondary side decode request
	input  wire logic        sec_valid,
	input  wire logic        sec_is_io,
	input  wire logic [31:0] sec_addr,
	input  wire logic        sec_in_window,
	output logic             sec_forward,
	// abort events
	input  wire logic        pci_master_abort,
	input  wire logic        pci_abort_is_read,
	input  wire logic        pci_abort_posted,
	input  wire logic        pcie_ur_received,
	output logic             pcie_send_ur,
	output logic             pci_signal_ta,
	output logic             posted_abort_err,
	output logic             abort_drop_write,
	output logic             abort_rdata_valid,
	output logic      [31:0] abort_rdata,
	// interrupt
	output logic             irq
);
	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	logic [15:0]        ctrl_r;
	logic [IRQ_NUM-1:0] irq_stat_r;
	logic [IRQ_NUM-1:0] irq_en_r;
	logic [IRQ_NUM-1:0] irq_evt;
	logic               abort_mode;
	logic               vga_en;
	logic               full_dec;
	logic               isa_en;
	bavd_abort_t        ab_state_r;
	bavd_abort_t        ab_state_nxt;
	logic               ma_report;
	logic               ur_report;
	logic               ma_read_quiet;
	logic               ma_write_quiet;
	logic               ma_posted_err;

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	// status, enable and clear share the low end of one 16 bit word
	if (IRQ_NUM < 1 || IRQ_NUM > 16) begin : g_chk_irq_num
		$error("interrupt count does not fit the register word");
	end
	// every control field has to sit inside the 16 bit control word
	if (BIT_ISA_ENABLE > 15 || BIT_VGA_ENABLE > 15
		|| BIT_FULL_DECODE > 15 || BIT_ABORT_MODE > 15) begin : g_chk_fields
		$error("control field outside the control word");
	end
	// event positions have to land inside the status word
	if (IRQ_UR_SENT >= IRQ_NUM || IRQ_TA_SENT >= IRQ_NUM
		|| IRQ_PW_ERR >= IRQ_NUM) begin : g_chk_events
		$error("event bit outside the status word");
	end

	// ------------------------------------------------------------------
	// control fields
	// ------------------------------------------------------------------
	assign abort_mode = ctrl_r[BIT_ABORT_MODE];
	assign vga_en     = ctrl_r[BIT_VGA_ENABLE];
	assign full_dec   = ctrl_r[BIT_FULL_DECODE];
	assign isa_en     = ctrl_r[BIT_ISA_ENABLE];

	// ------------------------------------------------------------------
	// control register
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_r <= BRIDGE_CONTROL_RST;
		end else if (reg_wr && reg_addr == ADDR_BRIDGE_CONTROL) begin
			// isa bit kept here since the isa block is decoded alongside
			ctrl_r <= reg_wdata & (BRIDGE_CONTROL_MASK
				| (16'h0001 << BIT_ISA_ENABLE));
		end
	end

	// ------------------------------------------------------------------
	// interrupt registers
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_en_r <= '0;
		end else if (reg_wr && reg_addr == ADDR_IRQ_ENABLE) begin
			irq_en_r <= reg_wdata[IRQ_NUM-1:0];
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			irq_stat_r <= '0;
		end else if (reg_wr && reg_addr == ADDR_IRQ_CLEAR) begin
			irq_stat_r <= (irq_stat_r & ~reg_wdata[IRQ_NUM-1:0]) | irq_evt;
		end else begin
			irq_stat_r <= irq_stat_r | irq_evt;
		end
	end

	assign irq = |(irq_stat_r & irq_en_r);

	// ------------------------------------------------------------------
	// register read back
	// ------------------------------------------------------------------
	// data stand for the one cycle after the strobe, zero otherwise
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				ADDR_BRIDGE_CONTROL: reg_rdata <= ctrl_r;
				ADDR_IRQ_STATUS:     reg_rdata <= 16'(irq_stat_r);
				ADDR_IRQ_ENABLE:     reg_rdata <= 16'(irq_en_r);
				default:             reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic logic vga_io_hit(input logic [31:0] a,
	                                    input logic        full);
		logic low_ok;
		logic alias_ok;
		low_ok = (a[9:0] >= VGA_IO_A_LO && a[9:0] <= VGA_IO_A_HI)
		      || (a[9:0] >= VGA_IO_B_LO && a[9:0] <= VGA_IO_B_HI);
		alias_ok = !full || a[15:10] == ISA_ALIAS_ZERO;
		return a[31:16] == IO_UPPER_ZERO && low_ok && alias_ok;
	endfunction

	function automatic logic vga_mem_hit(input logic [31:0] a);
		return a >= VGA_MEM_LO && a <= VGA_MEM_HI;
	endfunction

	// ------------------------------------------------------------------
	// decode terms
	// ------------------------------------------------------------------
	logic pri_vga_io;
	logic pri_vga_mem;
	logic sec_vga;
	logic pri_isa_block;
	logic pri_win_ok;
	logic pri_vga_ok;

	// full decode is only consulted under vga enable
	assign pri_vga_io  = vga_en && pri_is_io
		&& vga_io_hit(pri_addr, full_dec);
	assign pri_vga_mem = vga_en && !pri_is_io && vga_mem_hit(pri_addr);
	assign sec_vga     = vga_en && (sec_is_io
		? vga_io_hit(sec_addr, full_dec)
		: vga_mem_hit(sec_addr));
	// isa blocking touches the window path only, never a vga hit
	assign pri_isa_block = isa_en && pri_is_io
		&& pri_addr[31:16] == IO_UPPER_ZERO
		&& pri_addr[9:8] != ISA_LOW_QUARTER;
	assign pri_win_ok = pri_in_window && !pri_isa_block
		&& (pri_is_io ? io_space_enable : memory_space_enable);

	// vga hit bypasses isa and window terms entirely, only the command
	// register enables still gate it
	assign pri_vga_ok = (pri_vga_io && io_space_enable)
		|| (pri_vga_mem && memory_space_enable);

	// ------------------------------------------------------------------
	// forward outputs
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pri_forward <= 1'b0;
		end else begin
			pri_forward <= pri_valid
				&& (pri_vga_ok || pri_win_ok);
		end
	end

	// a vga hit stays on the secondary side even outside the window
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sec_forward <= 1'b0;
		end else begin
			sec_forward <= sec_valid && !sec_in_window && !sec_vga;
		end
	end

	// ------------------------------------------------------------------
	// abort handling
	// ------------------------------------------------------------------
	assign ma_report = pci_master_abort && abort_mode;
	assign ur_report = pcie_ur_received && abort_mode;

	// both events in one cycle: both sides get their answer
	always_comb begin
		ab_state_nxt = AB_IDLE;
		case ({ma_report, ur_report})
			2'h1:    ab_state_nxt = AB_TA;
			2'h2:    ab_state_nxt = AB_UR;
			2'h3:    ab_state_nxt = AB_BOTH;
			default: ab_state_nxt = AB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ab_state_r <= AB_IDLE;
		end else begin
			ab_state_r <= ab_state_nxt;
		end
	end

	assign pcie_send_ur  = ab_state_r == AB_UR
		|| ab_state_r == AB_BOTH;
	assign pci_signal_ta = ab_state_r == AB_TA
		|| ab_state_r == AB_BOTH;

	// ------------------------------------------------------------------
	// abort outputs
	// ------------------------------------------------------------------
	// quiet mode: reads end with all ones, writes are dropped silently
	assign ma_read_quiet  = pci_master_abort && pci_abort_is_read
		&& !abort_mode;
	assign ma_write_quiet = pci_master_abort && !pci_abort_is_read
		&& !abort_mode;
	assign ma_posted_err  = pci_master_abort && pci_abort_posted
		&& abort_mode;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			posted_abort_err <= 1'b0;
		end else begin
			posted_abort_err <= ma_posted_err;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			abort_drop_write <= 1'b0;
		end else begin
			abort_drop_write <= ma_write_quiet;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			abort_rdata_valid <= 1'b0;
		end else begin
			abort_rdata_valid <= ma_read_quiet;
		end
	end

	// the data word is zero outside its valid pulse
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			abort_rdata <= 32'h00000000;
		end else begin
			abort_rdata <= ma_read_quiet
				? ABORT_READ_DATA : 32'h00000000;
		end
	end

	// ------------------------------------------------------------------
	// interrupt events
	// ------------------------------------------------------------------
	// taken from the next state so the status bit and the pulse agree
	assign irq_evt[IRQ_UR_SENT] = ab_state_nxt == AB_UR
		|| ab_state_nxt == AB_BOTH;
	assign irq_evt[IRQ_TA_SENT] = ab_state_nxt == AB_TA
		|| ab_state_nxt == AB_BOTH;
	assign irq_evt[IRQ_PW_ERR]  = ma_posted_err;

endmodule // bavd_bridge

// >>> rtl/bavd_pkg.sv
package bavd_pkg;
	// ------------------------------------------------------------------
	// register map (word addresses on the plain register port)
	// ------------------------------------------------------------------
	localparam logic [3:0]  ADDR_BRIDGE_CONTROL = 4'h0;
	localparam logic [3:0]  ADDR_IRQ_STATUS     = 4'h1;
	localparam logic [3:0]  ADDR_IRQ_ENABLE     = 4'h2;
	localparam logic [3:0]  ADDR_IRQ_CLEAR      = 4'h3;
	// ------------------------------------------------------------------
	// bridge control field positions
	// ------------------------------------------------------------------
	localparam int          BIT_ISA_ENABLE      = 2;
	localparam int          BIT_VGA_ENABLE      = 3;
	localparam int          BIT_FULL_DECODE     = 4;
	localparam int          BIT_ABORT_MODE      = 5;
	localparam logic [15:0] BRIDGE_CONTROL_RST  = 16'h0000;
	localparam logic [15:0] BRIDGE_CONTROL_MASK = 16'h0038;
	// ------------------------------------------------------------------
	// interrupt status bits
	// ------------------------------------------------------------------
	localparam int          IRQ_NUM             = 3;
	localparam int          IRQ_UR_SENT         = 0;
	localparam int          IRQ_TA_SENT         = 1;
	localparam int          IRQ_PW_ERR          = 2;
	// ------------------------------------------------------------------
	// legacy display ranges
	// ------------------------------------------------------------------
	localparam logic [31:0] VGA_MEM_LO          = 32'h000A0000;
	localparam logic [31:0] VGA_MEM_HI          = 32'h000BFFFF;
	localparam logic [9:0]  VGA_IO_A_LO         = 10'h3B0;
	localparam logic [9:0]  VGA_IO_A_HI         = 10'h3BB;
	localparam logic [9:0]  VGA_IO_B_LO         = 10'h3C0;
	localparam logic [9:0]  VGA_IO_B_HI         = 10'h3DF;
	localparam logic [15:0] IO_UPPER_ZERO       = 16'h0000;
	localparam logic [5:0]  ISA_ALIAS_ZERO      = 6'h00;
	// isa: low 256 bytes of each 1 KB block are forwarded, 768 blocked
	localparam logic [1:0]  ISA_LOW_QUARTER     = 2'h0;
	localparam logic [31:0] ABORT_READ_DATA     = 32'hFFFFFFFF;
	// ------------------------------------------------------------------
	// abort sequencer
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		AB_IDLE = 2'b00,
		AB_UR   = 2'b01,
		AB_TA   = 2'b10,
		AB_BOTH = 2'b11
	} bavd_abort_t;
endpackage
